/* File: rtl/block_load_store_unit.sv */
// block load/store sequencer: eight 8-byte pieces per 64-byte block
`timescale 1ns/1ns
`default_nettype none
`include "block_lsu_map.svh"

module block_load_store_unit #(
  parameter int ADDR_W     = `ADDR_BITS,
  parameter int DATA_W     = `DATA_BITS,
  parameter int REG_W      = `REG_BITS,
  parameter int FIFO_DEPTH = `FIFO_WORDS
) (
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic                    req_valid,
  output logic                         req_ready,
  input  wire logic                    req_store,
  input  wire logic                    req_commit,
  input  wire logic [ADDR_W-1:0]       req_addr,
  input  wire logic [REG_W-1:0]        req_reg,
  input  wire logic                    side_effect_page_flag,
  input  wire logic                    older_ord_valid,
  input  wire logic [ADDR_W-1:0]       older_ord_addr,
  input  wire logic                    younger_ord_valid,
  input  wire logic [ADDR_W-1:0]       younger_ord_addr,
  output logic                         younger_hold,
  input  wire logic                    barrier_pending,
  input  wire logic                    older_reg_valid,
  input  wire logic [REG_W-1:0]        older_reg,
  input  wire logic                    alu_valid,
  input  wire logic [REG_W-1:0]        alu_src_a,
  input  wire logic [REG_W-1:0]        alu_src_b,
  input  wire logic [REG_W-1:0]        alu_dst,
  output logic                         alu_stall,
  input  wire logic                    sd_valid,
  output logic                         sd_ready,
  input  wire logic [DATA_W-1:0]       sd_data,
  output logic                         tag_req,
  output logic [ADDR_W-1:0]            tag_addr,
  input  wire logic                    tag_ack,
  input  wire block_lsu_pkg::l1_state_e first_level_data_cache_state,
  input  wire block_lsu_pkg::l2_state_e l2_state,
  output logic                         xlat_req,
  output logic [ADDR_W-1:0]            xlat_addr,
  input  wire logic                    xlat_ack,
  input  wire logic                    xlat_miss,
  output logic                         acc_valid,
  input  wire logic                    acc_ready,
  output logic                         acc_write,
  output block_lsu_pkg::dest_e         acc_dest,
  output logic [ADDR_W-1:0]            acc_addr,
  output logic [DATA_W-1:0]            acc_wdata,
  input  wire logic                    acc_done,
  input  wire logic [DATA_W-1:0]       acc_rdata,
  output logic                         ld_wr_valid,
  output logic [REG_W-1:0]             ld_wr_reg,
  output logic [DATA_W-1:0]            ld_wr_data,
  output logic                         inv_valid,
  output logic                         inv_l1,
  output logic                         inv_l2,
  output logic [ADDR_W-1:0]            inv_addr,
  output logic                         translation_miss_trap,
  output logic [`PIECE_BITS-1:0]       trap_piece,
  output logic                         trap_mid_block,
  input  wire logic                    miss_handled,
  output logic                         done
);
  localparam int LW = ADDR_W - `LINE_SHIFT;

  block_lsu_pkg::fsm_e  state;
  block_lsu_pkg::plan_s plan;
  logic                 is_store;
  logic                 is_commit;
  logic                 side_effect;
  logic [LW-1:0]        line;
  logic [REG_W-1:0]     base_reg;
  logic [`PIECE_BITS-1:0] piece;
  logic                 xlat_clear;
  logic                 busy;
  logic                 start_block;
  logic                 last_piece;
  logic [ADDR_W-1:0]    piece_addr;

  word_stream_if #(.W(DATA_W)) fill_if ();
  word_stream_if #(.W(DATA_W)) drain_if ();

  // fifo fills independently so a block's eight register reads never wait on the caches
  word_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) store_fifo (
    .clk   (clk),
    .reset (reset),
    .push  (fill_if.sink),
    .pop   (drain_if.source)
  );

  function automatic logic same_line(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] b);
    return a[ADDR_W-1:`LINE_SHIFT] == b[ADDR_W-1:`LINE_SHIFT];
  endfunction : same_line

  // register r lies among block registers not yet done (offset >= first)
  function automatic logic in_block(input logic [REG_W-1:0] r,
                                    input logic [REG_W-1:0] base,
                                    input logic [`PIECE_BITS-1:0] first);
    logic [REG_W-1:0] off;
    off = r - base;
    return (off <= REG_W'(`PIECE_LAST)) && (off >= REG_W'(first));
  endfunction : in_block

  function automatic block_lsu_pkg::plan_s decide(
      input logic st, input logic commit,
      input block_lsu_pkg::l1_state_e l1, input block_lsu_pkg::l2_state_e l2);
    block_lsu_pkg::plan_s p;
    logic l1_held;
    logic l2_held;
    p       = '0;
    l1_held = (l1 != block_lsu_pkg::L1_ABSENT);
    l2_held = (l2 != block_lsu_pkg::L2_INVALID);
    p.dest  = block_lsu_pkg::DEST_MEM;
    if (!st) begin
      if (l1_held) begin
        p.dest = block_lsu_pkg::DEST_L1;
      end else if (l2_held) begin
        p.dest = block_lsu_pkg::DEST_L2;
      end
    end else if (commit) begin
      p.l1_inv = l1_held;
      p.l2_inv = l2_held;
    end else begin
      case (l1)
        block_lsu_pkg::L1_ABSENT: begin
          if (l2 == block_lsu_pkg::L2_EXCL || l2 == block_lsu_pkg::L2_MOD) begin
            p.dest = block_lsu_pkg::DEST_L2;
          end
        end
        block_lsu_pkg::L1_CLEAN_EXCL: begin
          p.dest   = block_lsu_pkg::DEST_L2;
          p.l1_inv = 1'b1;
        end
        block_lsu_pkg::L1_MOD_MOD: begin
          p.dest = block_lsu_pkg::DEST_L1;
        end
        block_lsu_pkg::L1_CLEAN_MOD: begin
          p.dest   = block_lsu_pkg::DEST_L2;
          p.l1_inv = 1'b1;
        end
        default: begin
          p.dest = block_lsu_pkg::DEST_MEM;
        end
      endcase
    end
    // only the single destination and the listed invalidations act
    return p;
  endfunction : decide

  assign busy       = (state != block_lsu_pkg::ST_IDLE);
  assign last_piece = (piece == `PIECE_LAST);
  assign piece_addr = {line, piece, `BYTE_ZERO};

  // an older conflicting access or register owner delays the start
  assign start_block = (older_ord_valid && same_line(older_ord_addr, req_addr))
                     || (older_reg_valid
                         && in_block(older_reg, req_reg, `PIECE_FIRST));
  assign req_ready   = !busy && !start_block;

  // a block store never holds younger accesses; barriers are software's job
  assign younger_hold = busy && !is_store && younger_ord_valid
                     && same_line(younger_ord_addr,
                                  {line, `PIECE_FIRST, `BYTE_ZERO});

  always_comb begin
    alu_stall = 1'b0;
    if (busy && alu_valid) begin
      if (is_store) begin
        alu_stall = in_block(alu_dst, base_reg, piece);
      end else begin
        alu_stall = in_block(alu_src_a, base_reg, piece)
                 || in_block(alu_src_b, base_reg, piece)
                 || in_block(alu_dst, base_reg, piece);
      end
    end
  end

  assign fill_if.valid = sd_valid;
  assign fill_if.data  = sd_data;
  assign sd_ready      = fill_if.ready;

  assign tag_req   = (state == block_lsu_pkg::ST_LOOKUP);
  assign tag_addr  = {line, `PIECE_FIRST, `BYTE_ZERO};
  assign xlat_req  = (state == block_lsu_pkg::ST_XLAT);
  assign xlat_addr = piece_addr;

  // pieces issue one at a time, held back while a barrier is open
  assign acc_valid = (state == block_lsu_pkg::ST_ACCESS) && !barrier_pending
                  && (!is_store || drain_if.valid);
  assign acc_write = is_store;
  assign acc_dest  = plan.dest;
  assign acc_addr  = piece_addr;
  assign acc_wdata = drain_if.data;
  assign drain_if.ready = acc_valid && acc_ready && is_store;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      is_store    <= 1'b0;
      is_commit   <= 1'b0;
      side_effect <= 1'b0;
      line        <= '0;
      base_reg    <= '0;
    end else if (req_valid && req_ready) begin
      is_store    <= req_store;
      is_commit   <= req_commit;
      side_effect <= side_effect_page_flag;
      line        <= req_addr[ADDR_W-1:`LINE_SHIFT];
      base_reg    <= req_reg;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      plan <= '0;
    end else if (tag_req && tag_ack) begin
      plan <= decide(is_store, is_commit, first_level_data_cache_state,
                     l2_state);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= block_lsu_pkg::ST_IDLE;
      piece <= `PIECE_FIRST;
    end else begin
      case (state)
        block_lsu_pkg::ST_IDLE: begin
          if (req_valid && req_ready) begin
            piece <= `PIECE_FIRST;
            state <= block_lsu_pkg::ST_LOOKUP;
          end
        end
        block_lsu_pkg::ST_LOOKUP: begin
          if (tag_ack) begin
            state <= block_lsu_pkg::ST_XLAT;
          end
        end
        block_lsu_pkg::ST_XLAT: begin
          if (xlat_ack) begin
            if (xlat_miss) begin
              state <= block_lsu_pkg::ST_TRAP;
            end else if (!is_store) begin
              state <= block_lsu_pkg::ST_ACCESS;
            end else if (last_piece) begin
              // every store piece is translated before any data moves
              piece <= `PIECE_FIRST;
              state <= block_lsu_pkg::ST_ACCESS;
            end else begin
              piece <= piece + 3'h1;
            end
          end
        end
        block_lsu_pkg::ST_ACCESS: begin
          if (acc_valid && acc_ready) begin
            state <= block_lsu_pkg::ST_WAIT;
          end
        end
        block_lsu_pkg::ST_WAIT: begin
          if (acc_done) begin
            if (last_piece) begin
              state <= (plan.l1_inv || plan.l2_inv) ? block_lsu_pkg::ST_INVAL
                                                    : block_lsu_pkg::ST_IDLE;
            end else begin
              piece <= piece + 3'h1;
              state <= is_store ? block_lsu_pkg::ST_ACCESS
                                : block_lsu_pkg::ST_XLAT;
            end
          end
        end
        block_lsu_pkg::ST_INVAL: begin
          state <= block_lsu_pkg::ST_IDLE;
        end
        block_lsu_pkg::ST_TRAP: begin
          // store data stays queued, so a retried store needs no refill
          if (miss_handled) begin
            piece <= `PIECE_FIRST;
            state <= block_lsu_pkg::ST_XLAT;
          end
        end
        default: begin
          state <= block_lsu_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      xlat_clear <= 1'b0;
    end else if (state == block_lsu_pkg::ST_IDLE
                 || state == block_lsu_pkg::ST_TRAP) begin
      xlat_clear <= 1'b0;
    end else if (xlat_req && xlat_ack && !xlat_miss && last_piece) begin
      xlat_clear <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      translation_miss_trap <= 1'b0;
      trap_piece            <= `PIECE_FIRST;
      trap_mid_block        <= 1'b0;
    end else begin
      translation_miss_trap <= xlat_req && xlat_ack && xlat_miss;
      if (xlat_req && xlat_ack && xlat_miss) begin
        trap_piece     <= piece;
        trap_mid_block <= (piece != `PIECE_FIRST) && !side_effect;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ld_wr_valid <= 1'b0;
      ld_wr_reg   <= '0;
      ld_wr_data  <= '0;
    end else begin
      ld_wr_valid <= (state == block_lsu_pkg::ST_WAIT) && acc_done && !is_store;
      if ((state == block_lsu_pkg::ST_WAIT) && acc_done && !is_store) begin
        ld_wr_reg  <= base_reg + REG_W'(piece);
        ld_wr_data <= acc_rdata;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      inv_valid <= 1'b0;
      inv_l1    <= 1'b0;
      inv_l2    <= 1'b0;
      inv_addr  <= '0;
      done      <= 1'b0;
    end else begin
      inv_valid <= (state == block_lsu_pkg::ST_INVAL);
      inv_l1    <= (state == block_lsu_pkg::ST_INVAL) && plan.l1_inv;
      inv_l2    <= (state == block_lsu_pkg::ST_INVAL) && plan.l2_inv;
      inv_addr  <= {line, `PIECE_FIRST, `BYTE_ZERO};
      done      <= busy && (state == block_lsu_pkg::ST_INVAL
                   || (state == block_lsu_pkg::ST_WAIT && acc_done
                       && last_piece && !plan.l1_inv && !plan.l2_inv));
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  AST_PIECE_OFFSET: assert property (
    acc_valid |-> acc_addr[`BYTE_BITS-1:0] == `BYTE_ZERO
                  && acc_addr[`LINE_SHIFT-1:`BYTE_BITS] == piece)
    else $error("piece address not on its 8-byte slot");

  AST_BARRIER_HOLD: assert property (
    barrier_pending |-> !acc_valid)
    else $error("piece issued while a barrier is open");

  AST_ORDER_START: assert property (
    (older_ord_valid && same_line(older_ord_addr, req_addr)) |-> !req_ready)
    else $error("block started ahead of an older conflicting access");

  AST_YOUNG_ORDER: assert property (
    (busy && younger_ord_valid) |-> (younger_hold == (!is_store
      && same_line(younger_ord_addr, tag_addr))))
    else $error("younger hold disagrees with block kind");

  AST_LOAD_RAW: assert property (
    (busy && !is_store && alu_valid && in_block(alu_src_a, base_reg, piece))
      |-> alu_stall)
    else $error("arithmetic read of a pending block load register");

  AST_LOAD_FROM_L1: assert property (
    (tag_req && tag_ack && !is_store
     && first_level_data_cache_state != block_lsu_pkg::L1_ABSENT)
      |=> acc_dest == block_lsu_pkg::DEST_L1)
    else $error("block load bypassed a held first-level line");

  AST_COMMIT_MEM: assert property (
    (acc_valid && is_store && is_commit) |-> acc_dest == block_lsu_pkg::DEST_MEM)
    else $error("committing block store not sent to memory");

  AST_EXCL_PLAN: assert property (
    (tag_req && tag_ack && is_store && !is_commit
     && first_level_data_cache_state == block_lsu_pkg::L1_CLEAN_EXCL)
      |=> plan.l1_inv && acc_dest == block_lsu_pkg::DEST_L2)
    else $error("clean/exclusive store plan wrong");

  AST_RESTART: assert property (
    (state == block_lsu_pkg::ST_TRAP && miss_handled)
      |=> state == block_lsu_pkg::ST_XLAT && piece == `PIECE_FIRST)
    else $error("block not restarted from its first piece");

  AST_STORE_XLAT_FIRST: assert property (
    (acc_valid && is_store) |-> xlat_clear)
    else $error("store data moved before all pieces translated");

  AST_TRAP_PULSE: assert property (
    (xlat_req && xlat_ack && xlat_miss) |=> translation_miss_trap
      && state == block_lsu_pkg::ST_TRAP)
    else $error("translation miss not reported");

endmodule : block_load_store_unit
`default_nettype wire

/* File: rtl/block_lsu_map.svh */
// offsets, field positions and counts for the block load/store unit
`ifndef BLOCK_LSU_MAP_SVH
`define BLOCK_LSU_MAP_SVH

`define PIECE_FIRST  3'h0
`define PIECE_LAST   3'h7
`define PIECE_BITS   3
`define BYTE_BITS    3
`define BYTE_ZERO    3'h0
`define LINE_SHIFT   6
`define FIFO_WORDS   8
`define DATA_BITS    64
`define ADDR_BITS    64
`define REG_BITS     6

`endif

/* File: rtl/block_lsu_pkg.sv */
// types shared by the block load/store unit
package block_lsu_pkg;

  typedef enum logic [2:0] {
    L1_ABSENT       = 3'h0,
    L1_CLEAN_SHARED = 3'h1,
    L1_CLEAN_OWNED  = 3'h2,
    L1_CLEAN_EXCL   = 3'h3,
    L1_MOD_MOD      = 3'h4,
    L1_CLEAN_MOD    = 3'h5
  } l1_state_e;

  typedef enum logic [2:0] {
    L2_INVALID = 3'h0,
    L2_SHARED  = 3'h1,
    L2_OWNED   = 3'h2,
    L2_EXCL    = 3'h3,
    L2_MOD     = 3'h4
  } l2_state_e;

  typedef enum logic [1:0] {
    DEST_L1  = 2'h0,
    DEST_L2  = 2'h1,
    DEST_MEM = 2'h2
  } dest_e;

  // gray along idle, lookup, translate, access, wait, invalidate
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_LOOKUP = 3'h1,
    ST_XLAT   = 3'h3,
    ST_ACCESS = 3'h2,
    ST_WAIT   = 3'h6,
    ST_INVAL  = 3'h7,
    ST_TRAP   = 3'h5
  } fsm_e;

  typedef struct packed {
    dest_e dest;
    logic  l1_inv;
    logic  l2_inv;
  } plan_s;

endpackage : block_lsu_pkg

/* File: rtl/word_stream_if.sv */
// valid/ready word stream between the unit and its store-data fifo
`timescale 1ns/1ns
`default_nettype none
interface word_stream_if #(parameter int W = 64);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface : word_stream_if
`default_nettype wire

/* File: rtl/word_fifo.sv */
// store-data fifo with parameter width and depth
`timescale 1ns/1ns
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 8
) (
  input  wire logic        clk,
  input  wire logic        reset,
  word_stream_if.sink      push,
  word_stream_if.source    pop
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             do_push;
  logic             do_pop;

  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : next_ptr

  assign push.ready = (count != (AW+1)'(DEPTH));
  assign pop.valid  = (count != '0);
  assign pop.data   = mem[rd_ptr];
  assign do_push    = push.valid && push.ready;
  assign do_pop     = pop.valid && pop.ready;

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr] <= push.data;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= next_ptr(wr_ptr);
      end
      if (do_pop) begin
        rd_ptr <= next_ptr(rd_ptr);
      end
      if (do_push && !do_pop) begin
        count <= count + (AW+1)'(1);
      end else if (do_pop && !do_push) begin
        count <= count - (AW+1)'(1);
      end
    end
  end
endmodule : word_fifo
`default_nettype wire

/* File: verification/block_mem_model.sv */
// cache hierarchy and memory stand-in facing the block unit
`timescale 1ns/1ns
`default_nettype none
module block_mem_model (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        slow,
  input  wire logic [3:0]  miss_at,
  input  wire logic        tag_req,
  output logic             tag_ack,
  input  wire logic        xlat_req,
  output logic             xlat_ack,
  output logic             xlat_miss,
  input  wire logic        acc_valid,
  output logic             acc_ready,
  input  wire logic [63:0] acc_addr,
  output logic             acc_done,
  output logic [63:0]      acc_rdata
);
  logic [1:0]  tick;
  logic [3:0]  nx;
  logic        armed;
  logic        pend;
  logic [63:0] a;
  logic        go;
  assign go = !slow || tick == 2'h3;
  assign tag_ack = tag_req && go;
  assign xlat_ack = xlat_req && go;
  // one drop of the translation per block, as another thread would do
  assign xlat_miss = xlat_ack && armed && nx == miss_at;
  // one access outstanding at a time
  assign acc_ready = acc_valid && !pend && go;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tick <= 2'h0;
      nx <= 4'h0;
      armed <= 1'b0;
      pend <= 1'b0;
      a <= 64'h0;
      acc_done <= 1'b0;
      acc_rdata <= 64'h0;
    end else begin
      tick <= tick + 2'h1;
      acc_done <= 1'b0;
      // idle data bus keeps changing so stale data never passes
      acc_rdata <= ~acc_rdata;
      if (tag_ack) begin
        nx <= 4'h0;
        armed <= 1'b1;
      end else if (xlat_miss) begin
        nx <= 4'h0;
        armed <= 1'b0;
      end else if (xlat_ack) begin
        nx <= nx + 4'h1;
      end
      if (acc_ready) begin
        pend <= 1'b1;
        a <= acc_addr;
      end else if (pend && go) begin
        // memory copy is always current, as after the system's invalidation
        pend <= 1'b0;
        acc_done <= 1'b1;
        acc_rdata <= {a[31:0] ^ 32'h5a5a5a5a, a[31:0]};
      end
    end
  end
endmodule : block_mem_model
`default_nettype wire

/* File: verification/tb_block_load_store_unit.sv */
// self-checking bench for the block load/store unit
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("Error %s expected %0h seen %0h", n, e, g); end end
module tb_block_load_store_unit;
  logic clk = 1'b0, reset = 1'b1, req_valid = 0, req_store = 0;
  logic req_commit = 0, side_effect_page_flag = 0, older_ord_valid = 0;
  logic younger_ord_valid = 0, barrier_pending = 0, older_reg_valid = 0;
  logic alu_valid = 0, sd_valid = 0, miss_handled = 0, slow = 0;
  logic [63:0] req_addr = 0, older_ord_addr = 0, younger_ord_addr = 0;
  logic [63:0] sd_data = 0, tag_addr, xlat_addr, acc_addr, acc_wdata;
  logic [63:0] acc_rdata, ld_wr_data, inv_addr, line, sdw [8];
  logic [5:0]  req_reg = 0, older_reg = 0, alu_src_a = 0, alu_src_b = 0;
  logic [5:0]  alu_dst = 0, ld_wr_reg, base;
  logic [3:0]  miss_at = 4'hf, ex;
  logic [2:0]  trap_piece;
  logic [31:0] r = 32'h8a6571c5;
  logic req_ready, younger_hold, alu_stall, sd_ready, tag_req, tag_ack;
  logic xlat_req, xlat_ack, xlat_miss, acc_valid, acc_ready, acc_write;
  logic acc_done, ld_wr_valid, inv_valid, inv_l1, inv_l2, done;
  logic translation_miss_trap, trap_mid_block, st, s1, s2;
  block_lsu_pkg::l1_state_e first_level_data_cache_state = block_lsu_pkg::L1_ABSENT;
  block_lsu_pkg::l2_state_e l2_state = block_lsu_pkg::L2_INVALID;
  block_lsu_pkg::dest_e     acc_dest;
  int n_errors = 0, checks = 0, k = 0, j = 0, x;
  block_load_store_unit block_load_store_unit_inst (.clk, .reset,
    .req_valid, .req_ready, .req_store, .req_commit, .req_addr, .req_reg,
    .side_effect_page_flag, .older_ord_valid, .older_ord_addr,
    .younger_ord_valid, .younger_ord_addr, .younger_hold, .barrier_pending,
    .older_reg_valid, .older_reg, .alu_valid, .alu_src_a, .alu_src_b,
    .alu_dst, .alu_stall, .sd_valid, .sd_ready, .sd_data, .tag_req,
    .tag_addr, .tag_ack, .first_level_data_cache_state, .l2_state,
    .xlat_req, .xlat_addr, .xlat_ack, .xlat_miss, .acc_valid, .acc_ready,
    .acc_write, .acc_dest, .acc_addr, .acc_wdata, .acc_done, .acc_rdata,
    .ld_wr_valid, .ld_wr_reg, .ld_wr_data, .inv_valid, .inv_l1, .inv_l2,
    .inv_addr, .translation_miss_trap, .trap_piece, .trap_mid_block,
    .miss_handled, .done);
  block_mem_model block_mem_model_inst (.clk, .reset, .slow, .miss_at,
    .tag_req, .tag_ack, .xlat_req, .xlat_ack, .xlat_miss, .acc_valid,
    .acc_ready, .acc_addr, .acc_done, .acc_rdata);
  always #5 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  // {destination, first-level invalidate, second-level invalidate}
  function automatic logic [3:0] plan(input logic s, c,
                                      input logic [2:0] a, b);
    logic [1:0] d;
    logic       i;
    logic       p;
    p = a != block_lsu_pkg::L1_ABSENT;
    i = 1'b0;
    d = block_lsu_pkg::DEST_MEM;
    if (!s) begin
      if (b != block_lsu_pkg::L2_INVALID) d = block_lsu_pkg::DEST_L2;
      if (p) d = block_lsu_pkg::DEST_L1;
    end else if (c) begin
      return {d, p, b != block_lsu_pkg::L2_INVALID};
    end else if (!p) begin
      if (b >= block_lsu_pkg::L2_EXCL) d = block_lsu_pkg::DEST_L2;
    end else if (a == block_lsu_pkg::L1_MOD_MOD) begin
      d = block_lsu_pkg::DEST_L1;
    end else if (a != block_lsu_pkg::L1_CLEAN_SHARED &&
                 a != block_lsu_pkg::L1_CLEAN_OWNED) begin
      d = block_lsu_pkg::DEST_L2;
      i = 1'b1;
    end
    return {d, i, 1'b0};
  endfunction : plan
  always @(posedge clk) begin
    if (acc_valid && acc_ready) begin
      `CHK("acc_addr", line + 64'(k * 8), acc_addr)
      `CHK("acc_dest", ex[3:2], acc_dest)
      `CHK("acc_write", st, acc_write)
      if (st) `CHK("acc_wdata", sdw[k[2:0]], acc_wdata)
      k++;
    end
    if (ld_wr_valid) begin
      `CHK("ld_wr_reg", base + 6'(j), ld_wr_reg)
      `CHK("ld_wr_data", {line[31:0] + 32'(j * 8) ^ 32'h5a5a5a5a,
           line[31:0] + 32'(j * 8)}, ld_wr_data)
      j++;
    end
    if (tag_req && tag_ack) `CHK("tag_addr", line, tag_addr)
    if (xlat_req && xlat_ack)
      `CHK("xlat_addr", line, {xlat_addr[63:6], 6'h0})
    if (inv_valid) begin
      `CHK("inv_addr", line, inv_addr)
      s1 |= inv_l1;
      s2 |= inv_l2;
    end
    if (barrier_pending) `CHK("acc_valid", 1'b0, acc_valid)
    if (translation_miss_trap) begin
      if (st) `CHK("writes_before_trap", 0, k)
      k = 0;
      j = 0;
    end
  end
  task automatic complete_run();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  task automatic do_block(input logic s, c, input logic [2:0] a, b,
                          input logic [3:0] m, input int bar);
    int i;
    @(negedge clk);
    r = lfsr(r);
    {st, k, j, s1, s2} = {s, 32'h0, 32'h0, 2'b00};
    line = {r, r[25:0], 6'h0};
    base = r[11:6];
    ex = plan(s, c, a, b);
    first_level_data_cache_state = block_lsu_pkg::l1_state_e'(a);
    l2_state = block_lsu_pkg::l2_state_e'(b);
    {miss_at, slow, side_effect_page_flag} = {m, r[3], r[4]};
    barrier_pending = bar > 0;
    {younger_ord_valid, alu_valid} = 2'b11;
    younger_ord_addr = line + 64'h38;
    {alu_dst, alu_src_a, alu_src_b} = {base + 6'h7, r[17:12], r[23:18]};
    for (i = 0; s && i < 9; i++) begin
      r = lfsr(r);
      if (i < 8) sdw[i[2:0]] = {r, ~r};
      sd_valid = i < 8;
      sd_data = {r, ~r};
      #1 `CHK("sd_ready", 1'(i < 8), sd_ready)
      @(negedge clk);
    end
    sd_valid = 0;
    {req_valid, req_store, req_commit, req_reg} = {2'b11 & {1'b1, s}, c, base};
    req_addr = line | 64'(r[5:0]);
    for (i = 0; i < 50 && !req_ready; i++) @(negedge clk);
    if (!req_ready) begin n_errors++; complete_run(); end
    @(negedge clk);
    req_valid = 0;
    `CHK("younger_hold", !s, younger_hold)
    `CHK("alu_stall", 1'b1, alu_stall)
    for (i = 0; i < 3000 && !done; i++) begin
      if (i == bar) barrier_pending = 0;
      miss_handled = translation_miss_trap;
      if (translation_miss_trap) begin
        `CHK("trap_piece", m[2:0], trap_piece)
        `CHK("trap_mid_block", m[2:0] != 0 && !side_effect_page_flag,
             trap_mid_block)
      end
      @(negedge clk);
    end
    if (!done) begin n_errors++; complete_run(); end
    @(negedge clk);
    `CHK("pieces", 8, k)
    if (!s) `CHK("loads", 8, j)
    `CHK("inv", ex[1:0], {s1, s2})
    {younger_ord_valid, alu_valid, miss_handled} = 3'b000;
  endtask : do_block
  initial begin
    repeat (20) @(negedge clk);
    reset = 0;
    {req_addr, older_ord_valid, older_ord_addr} = {64'h1000, 1'b1, 64'h103f};
    #1 `CHK("req_ready", 1'b0, req_ready)
    older_ord_addr = 64'h1040;
    #1 `CHK("req_ready", 1'b1, req_ready)
    {older_ord_valid, older_reg_valid, req_reg, older_reg} = 14'h1f03;
    #1 `CHK("req_ready", 1'b0, req_ready)
    older_reg = 6'h04;
    #1 `CHK("req_ready", 1'b1, req_ready)
    older_reg_valid = 0;
    for (x = 0; x < 30; x++) begin
      do_block(1, 0, x / 5, x % 5, 4'hf, 0);
      do_block(0, 0, x / 5, x % 5, 4'hf, 0);
    end
    for (x = 0; x < 6; x++) do_block(1, 1, x, x % 5, 4'hf, 0);
    do_block(0, 0, 0, 0, 4'h3, 0);
    do_block(0, 0, 1, 0, 4'h0, 0);
    do_block(1, 0, 4, 4, 4'h7, 0);
    do_block(0, 0, 3, 2, 4'hf, 30);
    complete_run();
  end
endmodule : tb_block_load_store_unit
`default_nettype wire
